/* src/wev_cfg_pkg.sv */
// Constants shared by the wake-up event configuration block.
package wev_cfg_pkg;

  // Register offsets, the same in every bank.
  localparam logic [3:0] WEV_OFS_EVENT_SELECT = 4'h0;
  localparam logic [3:0] WEV_OFS_STATE_ENABLE = 4'h1;

  // Reset values.
  localparam logic [7:0] WEV_SELECT_RESET = 8'h00;
  localparam logic [3:0] WEV_ENABLE_RESET = 4'h0;

  // Event select field layout.
  localparam int WEV_INDEX_LSB = 0;
  localparam int WEV_INDEX_MSB = 4;
  localparam int WEV_NUM_EVENTS = 32;

  // Field positions inside the state-enable register.
  localparam int WEV_BIT_PULSE_RAM = 3;
  localparam int WEV_BIT_PULSE_OFF = 2;
  localparam int WEV_BIT_POWER_RAM = 1;
  localparam int WEV_BIT_POWER_OFF = 0;

  // Writable bits per class; anything outside reads as zero.
  localparam logic [3:0] WEV_MASK_CLASS_A = 4'hF;
  localparam logic [3:0] WEV_MASK_CLASS_B = 4'h3;
  localparam logic [3:0] WEV_MASK_NONE = 4'h0;

  // Event codes with a special meaning.
  localparam logic [4:0] WEV_CODE_SLEEP_BUTTON = 5'h16;
  localparam logic [4:0] WEV_CODE_RESERVED_A = 5'h17;
  localparam logic [4:0] WEV_CODE_ALARM = 5'h18;
  localparam logic [4:0] WEV_CODE_CLASS_B_FIRST = 5'h19;
  localparam logic [4:0] WEV_CODE_CLASS_B_LAST = 5'h1B;
  localparam logic [4:0] WEV_CODE_RESERVED_B = 5'h1D;

  // Pulse output mode value that allows the power-button pulse.
  localparam logic WEV_PULSE_MODE_ENABLED = 1'b0;
  // State source value that marks this device as power-management controller.
  localparam logic WEV_STATE_SOURCE_LOCAL = 1'b0;

  // Writable mask of an event code, by its class.
  function automatic logic [3:0] wev_enable_mask(input logic [4:0] code);
    if (code == WEV_CODE_RESERVED_A || code == WEV_CODE_RESERVED_B)
    begin
      return WEV_MASK_NONE;
    end
    else if (code >= WEV_CODE_CLASS_B_FIRST && code <= WEV_CODE_CLASS_B_LAST)
    begin
      return WEV_MASK_CLASS_B;
    end
    else
    begin
      return WEV_MASK_CLASS_A;
    end
  endfunction

endpackage

/* src/wev_event_config.sv */
// Wake-up event select and state-enable registers with their output effects.
`timescale 1ns/1ps
module wev_event_config
  import wev_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // Host register path.
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [3:0] hostAddr,
  input wire logic [7:0] hostWdata,
  output logic [7:0] hostRdata,
  // Embedded controller register path.
  input wire logic ecWrite,
  input wire logic ecRead,
  input wire logic [3:0] ecAddr,
  input wire logic [7:0] ecWdata,
  output logic [7:0] ecRdata,
  // Event status flags, indexed by event code.
  input wire logic [31:0] generalEventStatus,
  input wire logic sleepButtonPmFlag,
  input wire logic alarmPmFlag,
  // Current sleep state and configuration bits.
  input wire logic suspendToRamState,
  input wire logic softOffState,
  input wire logic pulseOutputModeBit,
  input wire logic externalStateSourceBit,
  // Outputs.
  output logic powerButtonPulseOut,
  output logic mainPowerOnOutput
);

  typedef struct packed {
    logic [7:0] hostSelect;
    logic [7:0] ecSelect;
    logic [31:0][3:0] enableCfg;
    logic [31:0] prevActive;
    logic [7:0] hostRdata;
    logic [7:0] ecRdata;
    logic pulse;
    logic powerOn;
  } wev_state_t;

  wev_state_t state;
  wev_state_t next_state;
  logic [31:0] eventActive;
  logic [31:0] pulseTrigger;
  logic [31:0] powerTrigger;
  logic [4:0] hostIndex;
  logic [4:0] ecIndex;

  // index field taken from bits 4-0
  assign hostIndex = state.hostSelect[WEV_INDEX_MSB:WEV_INDEX_LSB];
  assign ecIndex = state.ecSelect[WEV_INDEX_MSB:WEV_INDEX_LSB];

  // Event code to active condition, covering all code groups.
  // GPIO codes mapped in order
  wev_event_map uMap (
    .generalEventStatus(generalEventStatus),
    .sleepButtonPmFlag(sleepButtonPmFlag),
    .alarmPmFlag(alarmPmFlag),
    .eventActive(eventActive)
  );

  // Per-event output requests on the rising edge of activity. An edge is used so that a
  // status bit left set does not retrigger the pulse every cycle.
  genvar e;
  generate
    for (e = 0; e < WEV_NUM_EVENTS; e++)
    begin : gTrig
      logic rise;
      assign rise = eventActive[e] & ~state.prevActive[e];
      assign pulseTrigger[e] = rise &
        ((state.enableCfg[e][WEV_BIT_PULSE_RAM] & suspendToRamState) |
         (state.enableCfg[e][WEV_BIT_PULSE_OFF] & softOffState));
      assign powerTrigger[e] = rise &
        ((state.enableCfg[e][WEV_BIT_POWER_RAM] & suspendToRamState) |
         (state.enableCfg[e][WEV_BIT_POWER_OFF] & softOffState));
    end
  endgenerate

  // Read value of either path for a given offset and its own select register.
  function automatic logic [7:0] read_value(input logic [3:0] addr, input logic [7:0] sel,
                                            input logic [31:0][3:0] cfg);
    logic [4:0] idx;
    idx = sel[WEV_INDEX_MSB:WEV_INDEX_LSB];
    if (addr == WEV_OFS_EVENT_SELECT)
    begin
      return sel;
    end
    else if (addr == WEV_OFS_STATE_ENABLE)
    begin
      return {4'h0, cfg[idx] & wev_enable_mask(idx)};
    end
    else
    begin
      // Offsets outside this pair belong to other logic and read as zero here.
      return 8'h00;
    end
  endfunction

  // Next-state logic for both register paths and both outputs.
  always_comb
  begin
    next_state = state;
    next_state.prevActive = eventActive;

    // controller path uses its own select
    if (ecWrite && ecAddr == WEV_OFS_EVENT_SELECT)
    begin
      next_state.ecSelect = ecWdata;
    end
    if (ecWrite && ecAddr == WEV_OFS_STATE_ENABLE)
    begin
      next_state.enableCfg[ecIndex] = ecWdata[3:0] & wev_enable_mask(ecIndex);
    end

    // Host writes are applied last, so when both paths hit one event in the same cycle
    // the host value is kept.
    // host path uses its own select
    if (hostWrite && hostAddr == WEV_OFS_EVENT_SELECT)
    begin
      next_state.hostSelect = hostWdata;
    end
    if (hostWrite && hostAddr == WEV_OFS_STATE_ENABLE)
    begin
      next_state.enableCfg[hostIndex] = hostWdata[3:0] & wev_enable_mask(hostIndex);
    end

    // Read data is registered and holds until the next read on that path.
    if (hostRead)
    begin
      next_state.hostRdata = read_value(hostAddr, state.hostSelect, state.enableCfg);
    end
    if (ecRead)
    begin
      next_state.ecRdata = read_value(ecAddr, state.ecSelect, state.enableCfg);
    end

    // pulse only in pulse mode zero
    next_state.pulse = (|pulseTrigger) && (pulseOutputModeBit == WEV_PULSE_MODE_ENABLED);

    // Main power stays on once requested; it drops again when the device is out of both
    // sleep states, which leaves the running system in charge of the supply.
    // power-on only as local controller
    if ((|powerTrigger) && (externalStateSourceBit == WEV_STATE_SOURCE_LOCAL))
    begin
      next_state.powerOn = 1'b1;
    end
    else if (!suspendToRamState && !softOffState)
    begin
      next_state.powerOn = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state.hostSelect <= WEV_SELECT_RESET;
      state.ecSelect <= WEV_SELECT_RESET;
      state.enableCfg <= '{default: WEV_ENABLE_RESET};
      state.prevActive <= '0;
      state.hostRdata <= 8'h00;
      state.ecRdata <= 8'h00;
      state.pulse <= 1'b0;
      state.powerOn <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops.
  assign hostRdata = state.hostRdata;
  assign ecRdata = state.ecRdata;
  assign powerButtonPulseOut = state.pulse;
  assign mainPowerOnOutput = state.powerOn;

endmodule // wev_event_config

/* src/wev_event_map.sv */
// Maps the status flags onto the 32 wake-up event active conditions.
`timescale 1ns/1ps
module wev_event_map
  import wev_cfg_pkg::*;
(
  input wire logic [31:0] generalEventStatus,
  input wire logic sleepButtonPmFlag,
  input wire logic alarmPmFlag,
  output logic [31:0] eventActive
);

  // Each code except the two reserved ones looks at its own status bit; two codes also OR in a power-management flag.
  genvar i;
  generate
    for (i = 0; i < WEV_NUM_EVENTS; i++)
    begin : gMap
      if (i == int'(WEV_CODE_RESERVED_A) || i == int'(WEV_CODE_RESERVED_B))
      begin : gRes
        // Reserved codes never become active.
        assign eventActive[i] = 1'b0;
      end
      else if (i == int'(WEV_CODE_SLEEP_BUTTON))
      begin : gSlp
        assign eventActive[i] = generalEventStatus[i] | sleepButtonPmFlag;
      end
      else if (i == int'(WEV_CODE_ALARM))
      begin : gAlm
        assign eventActive[i] = generalEventStatus[i] | alarmPmFlag;
      end
      else
      begin : gGen
        assign eventActive[i] = generalEventStatus[i];
      end
    end
  endgenerate

endmodule // wev_event_map

/* tb/tb.sv */
// Self-checking bench for the wake-up event configuration block.
`timescale 1ns/1ps
module tb;
  import wev_cfg_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, hostWrite, hostRead, ecWrite, ecRead;
  logic [3:0] hostAddr, ecAddr;
  logic [7:0] hostWdata, hostRdata, ecWdata, ecRdata;
  logic [31:0] generalEventStatus = 32'h0000_0000, seed = 32'h0000_783d, r;
  logic sleepButtonPmFlag = 1'b0, alarmPmFlag = 1'b0, suspendToRamState = 1'b0;
  logic softOffState = 1'b0, pulseOutputModeBit = 1'b0, externalStateSourceBit = 1'b0;
  logic powerButtonPulseOut, mainPowerOnOutput;
  logic [7:0] mSel [2] = '{8'h00, 8'h00};
  logic [3:0] mEn [32] = '{default: 4'h0};
  logic [4:0] tc [4] = '{5'h00, 5'h16, 5'h18, 5'h19};
  logic [7:0] tv [4] = '{8'h05, 8'h0A, 8'h0F, 8'h0F};
  int nFail = 0, checksDone = 0;
  wev_event_config u_dut (.*);
  wev_reg_agent uHost (.clk(clk), .wr(hostWrite), .rd(hostRead), .addr(hostAddr),
    .wdata(hostWdata), .rdata(hostRdata));
  wev_reg_agent uEc (.clk(clk), .wr(ecWrite), .rd(ecRead), .addr(ecAddr),
    .wdata(ecWdata), .rdata(ecRdata));
  // Free-running 40 MHz clock.
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Writable bits of each code, kept apart from the design's own table.
  function automatic logic [3:0] msk(input logic [4:0] c);
    if (c == 5'h17 || c == 5'h1D) return 4'h0;
    return (c >= 5'h19 && c <= 5'h1B) ? 4'h3 : 4'hF;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e)
    begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic testDone();
    if (nFail == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One register access on path p, mirrored in the model; reads are compared.
  task automatic acc(input int p, input logic w, input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [7:0] e;
    logic [4:0] c;
    c = mSel[p][4:0];
    e = (a == 4'h0) ? mSel[p] : (a == 4'h1) ? {4'h0, mEn[c]} : 8'h00;
    if (p == 0) uHost.put(w, a, d, q);
    else uEc.put(w, a, d, q);
    if (w && a == 4'h0) mSel[p] = d;
    if (w && a == 4'h1) mEn[c] = d[3:0] & msk(c);
    if (!w) chk("rdata", e, q);
  endtask
  // Raise one event source in a given state and compare both outputs with the model.
  task automatic trig(input int b, input logic [4:0] c, input logic ram, off, md, ex);
    logic ep;
    logic ew;
    {suspendToRamState, softOffState, pulseOutputModeBit, externalStateSourceBit} =
      {ram, off, md, ex};
    ep = ((mEn[c][3] & ram) | (mEn[c][2] & off)) & !md;
    ew = ((mEn[c][1] & ram) | (mEn[c][0] & off)) & !ex;
    @(posedge clk) #1;
    if (b < 32) generalEventStatus[b] = 1'b1;
    else if (b == 32) sleepButtonPmFlag = 1'b1;
    else alarmPmFlag = 1'b1;
    @(posedge clk) #1;
    chk("pulse", {7'h00, ep}, {7'h00, powerButtonPulseOut});
    chk("power", {7'h00, ew}, {7'h00, mainPowerOnOutput});
    generalEventStatus = 32'h0000_0000;
    {sleepButtonPmFlag, alarmPmFlag, suspendToRamState, softOffState} = 4'h0;
    @(posedge clk) #1;
  endtask
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      acc(p, 1'b0, 4'h0, 8'h00);
      acc(p, 1'b0, 4'h1, 8'h00);
    end
    for (int c = 0; c < 32; c++)
    begin
      r = rnd();
      acc(0, 1'b1, 4'h0, {r[7:5], 5'(c)});
      acc(0, 1'b0, 4'h0, 8'h00);
      acc(0, 1'b1, 4'h1, r[15:8]);
      acc(0, 1'b0, 4'h1, 8'h00);
      acc(1, 1'b1, 4'h0, {3'h0, 5'(31 - c)});
      acc(1, 1'b1, 4'h1, r[23:16]);
      acc(0, 1'b0, 4'h1, 8'h00);
      acc(1, 1'b0, 4'h1, 8'h00);
    end
    acc(0, 1'b1, 4'h5, 8'hFF);
    acc(0, 1'b0, 4'h5, 8'h00);
    acc(1, 1'b0, 4'h9, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      acc(0, 1'b1, 4'h0, {3'h0, tc[i]});
      acc(0, 1'b1, 4'h1, tv[i]);
    end
    for (int m = 0; m < 4; m++) trig(0, 5'h00, 1'b0, 1'b1, m[1], m[0]);
    trig(0, 5'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    trig(32, 5'h16, 1'b1, 1'b0, 1'b0, 1'b0);
    trig(33, 5'h18, 1'b0, 1'b1, 1'b0, 1'b0);
    trig(25, 5'h19, 1'b1, 1'b0, 1'b0, 1'b0);
    testDone();
  end
  // Watchdog well past the expected run length.
  initial
  begin
    #(25 * 5000);
    nFail++;
    testDone();
  end
endmodule // tb
bind wev_event_config wev_cfg_chk u_chk (.*);

/* tb/wev_cfg_chk.sv */
// Port assertions for the wake-up event configuration block.
`timescale 1ns/1ps
module wev_cfg_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic [3:0] hostAddr,
  input wire logic [7:0] hostWdata,
  input wire logic [7:0] hostRdata,
  input wire logic ecRead,
  input wire logic [3:0] ecAddr,
  input wire logic [7:0] ecRdata,
  input wire logic suspendToRamState,
  input wire logic softOffState,
  input wire logic pulseOutputModeBit,
  input wire logic externalStateSourceBit,
  input wire logic powerButtonPulseOut,
  input wire logic mainPowerOnOutput
);
  // Everything here runs on the one clock and sleeps through reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  pulse_one_cycle_a: assert property (powerButtonPulseOut |=> !powerButtonPulseOut)
    else $error("power button pulse lasted more than one cycle");
  pulse_mode_a: assert property (powerButtonPulseOut |-> !$past(pulseOutputModeBit))
    else $error("pulse issued while pulse mode forbids it");
  pulse_state_a: assert property (powerButtonPulseOut |-> $past(suspendToRamState || softOffState))
    else $error("pulse issued outside both sleep states");
  power_source_a: assert property ($rose(mainPowerOnOutput) |-> !$past(externalStateSourceBit))
    else $error("main power switched on under an external state source");
  power_clear_a: assert property (!suspendToRamState && !softOffState |=> !mainPowerOnOutput)
    else $error("main power stayed on with no sleep state");
  select_readback_a: assert property ((hostWrite && !hostRead && hostAddr == 4'h0) ##1 !hostWrite
    ##1 (hostRead && hostAddr == 4'h0) |=> hostRdata == $past(hostWdata, 3))
    else $error("host select did not read back as written");
  host_unmapped_a: assert property (hostRead && hostAddr > 4'h1 |=> hostRdata == 8'h00)
    else $error("host read of an unmapped offset was not zero");
  ec_unmapped_a: assert property (ecRead && ecAddr > 4'h1 |=> ecRdata == 8'h00)
    else $error("controller read of an unmapped offset was not zero");
  rdata_hold_a: assert property (!hostRead |=> $stable(hostRdata))
    else $error("host read data changed without a read");
endmodule // wev_cfg_chk

/* tb/wev_reg_agent.sv */
// Register access agent standing in for the host or the embedded controller.
`timescale 1ns/1ps
module wev_reg_agent (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // Strobes idle low from time zero.
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'hF;
    wdata = 8'h00;
  end
  task automatic put(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk) #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clk) #1;
    q = rdata;
    wr = 1'b0;
    rd = 1'b0;
    // Idle fields are inverted so a design that peeks at them sees garbage.
    addr = ~a;
    wdata = ~d;
  endtask
endmodule // wev_reg_agent
